// ===== core/interrupt_vector_resolver.sv
// Interrupt source classification and vector resolution, with AHB-Lite registers.
// Assumes the CPU core reports instruction starts, completions and traps on hclk,
// and acknowledges an interrupt by reading the acknowledge register.
`timescale 1ns/1ns
`default_nettype none
module interrupt_vector_resolver (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic key_input_pin,
  input wire logic external_request_pin_a,
  input wire logic external_request_pin_b,
  input wire logic [ivr_pkg::NPERIPH-1:0] periph_req,
  input wire logic instr_start,
  input wire logic [19:0] instr_addr,
  input wire logic instr_done,
  input wire logic undefined_opcode_instruction,
  input wire logic overflow_trap,
  input wire logic break_instruction,
  input wire logic [31:0] break_fixed_word,
  input wire logic sw_trap_valid,
  input wire logic [5:0] sw_trap_num,
  input wire logic watchdog_event,
  input wire logic debugger_break,
  output logic int_pending,
  output logic int_special,
  output logic [5:0] int_number,
  output logic [2:0] int_level,
  output logic [19:0] int_vector
);

  typedef struct packed {
    logic iflag;
    logic [2:0] processor_priority_level;
    logic step;
    logic amen;
    logic [19:0] vector_table_base_register;
    logic [19:0] match;
    logic [ivr_pkg::NSRC-1:0] req;
    logic [ivr_pkg::NSRC-1:0][2:0] lvl;
    logic [ivr_pkg::NSPC-1:0] spend;
    logic [5:0] swnum;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic ready;
    logic resp;
    logic [31:0] rdata;
    logic pvalid;
    logic pspec;
    logic [3:0] pidx;
    logic [5:0] pnum;
    logic [2:0] plvl;
    logic [19:0] pvec;
  } state_t;

  state_t s_q;
  state_t s_d;
  pin_evt_if evt ();

  pin_event_stage u_pins (
    .hclk(hclk),
    .hresetn(hresetn),
    .key_input_pin(key_input_pin),
    .external_request_pin_a(external_request_pin_a),
    .external_request_pin_b(external_request_pin_b),
    .evt(evt)
  );

  always_comb begin
    logic [ivr_pkg::NSRC-1:0] set_req;
    logic [ivr_pkg::NSRC-1:0] clr_req;
    logic [ivr_pkg::NSPC-1:0] set_sp;
    logic [ivr_pkg::NSPC-1:0] clr_sp;
    logic [31:0] rd;
    logic [4:0] li;
    logic [2:0] best;
    s_d = s_q;
    set_req = '0;
    clr_req = '0;
    set_sp = '0;
    clr_sp = '0;
    rd = 32'h00000000;
    li = 5'h00;
    best = 3'h0;
    s_d.ready = 1'b1;
    s_d.resp = 1'b0;

    // Write data phase: hwdata belongs to the address taken one cycle earlier.
    if (s_q.wr_pend) begin
      li = ivr_pkg::lvl_index(s_q.wr_addr);
      case (s_q.wr_addr)
        ivr_pkg::OFF_CTRL: begin
          s_d.iflag = hwdata[ivr_pkg::CTRL_IFLAG];
          s_d.processor_priority_level = hwdata[ivr_pkg::CTRL_IPL_LSB +: 3];
          s_d.step = hwdata[ivr_pkg::CTRL_STEP];
          s_d.amen = hwdata[ivr_pkg::CTRL_AMEN];
        end
        ivr_pkg::OFF_BASE: s_d.vector_table_base_register = hwdata[19:0];
        ivr_pkg::OFF_MATCH: s_d.match = hwdata[19:0];
        default: begin
          if (li[4]) begin
            s_d.lvl[li[3:0]] = hwdata[2:0];
            // Software may only clear a request; writing a one leaves it alone.
            if (!hwdata[ivr_pkg::LVL_REQ]) begin
              clr_req[li[3:0]] = 1'b1;
            end
          end
        end
      endcase
    end

    s_d.wr_pend = 1'b0;
    if (hsel && htrans[1] && hready) begin
      if (hwrite) begin
        s_d.wr_pend = 1'b1;
        s_d.wr_addr = haddr[7:0];
      end else begin
        li = ivr_pkg::lvl_index(haddr[7:0]);
        case (haddr[7:0])
          ivr_pkg::OFF_ACK: begin
            rd[ivr_pkg::ACK_VALID] = s_q.pvalid;
            rd[ivr_pkg::ACK_SPC] = s_q.pspec;
            rd[ivr_pkg::ACK_LVL_LSB +: 3] = s_q.plvl;
            rd[ivr_pkg::ACK_NUM_LSB +: 6] = s_q.pnum;
            // Acknowledge read retires the presented source.
            if (s_q.pvalid && s_q.pspec) begin
              clr_sp[s_q.pidx[2:0]] = 1'b1;
            end else if (s_q.pvalid) begin
              clr_req[s_q.pidx] = 1'b1;
            end
          end
          ivr_pkg::OFF_CTRL: begin
            rd[ivr_pkg::CTRL_IFLAG] = s_q.iflag;
            rd[ivr_pkg::CTRL_IPL_LSB +: 3] = s_q.processor_priority_level;
            rd[ivr_pkg::CTRL_STEP] = s_q.step;
            rd[ivr_pkg::CTRL_AMEN] = s_q.amen;
          end
          ivr_pkg::OFF_BASE: rd[19:0] = s_q.vector_table_base_register;
          ivr_pkg::OFF_MATCH: rd[19:0] = s_q.match;
          ivr_pkg::OFF_VECTOR: rd[19:0] = s_q.pvec;
          default: begin
            if (li[4]) begin
              rd[2:0] = s_q.lvl[li[3:0]];
              rd[ivr_pkg::LVL_REQ] = s_q.req[li[3:0]];
            end
          end
        endcase
      end
      s_d.rdata = rd;
    end

    // Request capture, every peripheral goes into the maskable set.
    set_req[0] = evt.key_low;
    for (int i = 1; i <= ivr_pkg::NPERIPH; i++) begin
      set_req[i] = periph_req[i-1];
    end
    set_req[12] = evt.edge_a;
    set_req[13] = evt.edge_b;
    // A request arriving with its clear is kept.
    s_d.req = (s_q.req & ~clr_req) | set_req;

    set_sp[ivr_pkg::SP_DBC] = debugger_break;
    set_sp[ivr_pkg::SP_WDT] = watchdog_event;
    set_sp[ivr_pkg::SP_STEP] = instr_done && s_q.step;
    // Only instruction starts are compared, so a mid-instruction address never matches.
    set_sp[ivr_pkg::SP_AMATCH] = instr_start && s_q.amen && (instr_addr == s_q.match);
    set_sp[ivr_pkg::SP_BRK] = break_instruction;
    set_sp[ivr_pkg::SP_UND] = undefined_opcode_instruction;
    set_sp[ivr_pkg::SP_OVF] = overflow_trap;
    set_sp[ivr_pkg::SP_SWI] = sw_trap_valid;
    if (sw_trap_valid) begin
      s_d.swnum = sw_trap_num;
    end
    s_d.spend = (s_q.spend & ~clr_sp) | set_sp;

    // Presentation is taken from the next state so a read never sees a retired source.
    s_d.pvalid = 1'b0;
    s_d.pspec = 1'b0;
    s_d.pidx = 4'h0;
    s_d.pnum = 6'h00;
    s_d.plvl = 3'h0;
    s_d.pvec = 20'h00000;
    if (s_d.iflag) begin
      for (int i = ivr_pkg::NSRC - 1; i >= 0; i--) begin
        // Descending scan with >= keeps the lowest index on equal levels.
        if (s_d.req[i] && s_d.lvl[i] > s_d.processor_priority_level
            && s_d.lvl[i] >= best) begin
          best = s_d.lvl[i];
          s_d.pvalid = 1'b1;
          s_d.pidx = 4'(i);
          s_d.plvl = s_d.lvl[i];
          s_d.pnum = ivr_pkg::src_trap(i);
          s_d.pvec = ivr_pkg::entry_addr(s_d.vector_table_base_register,
                                         ivr_pkg::src_trap(i));
        end
      end
    end
    // Specials override any maskable choice regardless of flag and levels.
    for (int k = ivr_pkg::NSPC - 1; k >= 0; k--) begin
      if (s_d.spend[k]) begin
        s_d.pvalid = 1'b1;
        s_d.pspec = 1'b1;
        s_d.pidx = 4'(k);
        s_d.plvl = 3'h0;
        case (k)
          ivr_pkg::SP_DBC: s_d.pnum = ivr_pkg::SLOT_DBC;
          ivr_pkg::SP_WDT: s_d.pnum = ivr_pkg::SLOT_WDT;
          ivr_pkg::SP_STEP: s_d.pnum = ivr_pkg::SLOT_STEP;
          ivr_pkg::SP_AMATCH: s_d.pnum = ivr_pkg::SLOT_AMATCH;
          ivr_pkg::SP_BRK: s_d.pnum = ivr_pkg::SLOT_BRK;
          ivr_pkg::SP_UND: s_d.pnum = ivr_pkg::SLOT_UND;
          ivr_pkg::SP_OVF: s_d.pnum = ivr_pkg::SLOT_OVF;
          default: s_d.pnum = s_d.swnum;
        endcase
        s_d.pvec = ivr_pkg::entry_addr(ivr_pkg::FIX_TABLE_BASE, s_d.pnum);
        if (k == ivr_pkg::SP_SWI) begin
          s_d.pvec = ivr_pkg::entry_addr(s_d.vector_table_base_register, s_d.swnum);
        end
        if (k == ivr_pkg::SP_BRK && break_fixed_word == ivr_pkg::BRK_ERASED) begin
          s_d.pvec = ivr_pkg::entry_addr(s_d.vector_table_base_register,
                                         ivr_pkg::TRAP_BRK);
        end
      end
    end
  end

  // The reset pin is hresetn itself; holding it low keeps every flop at its reset value.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '{iflag: 1'b0, processor_priority_level: ivr_pkg::IPL_RST,
               vector_table_base_register: ivr_pkg::BASE_RST, match: ivr_pkg::MATCH_RST,
               lvl: {ivr_pkg::NSRC{ivr_pkg::LVL_RST}}, ready: 1'b1, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign hrdata = s_q.rdata;
  assign hreadyout = s_q.ready;
  assign hresp = s_q.resp;
  assign int_pending = s_q.pvalid;
  assign int_special = s_q.pspec;
  assign int_number = s_q.pnum;
  assign int_level = s_q.plvl;
  assign int_vector = s_q.pvec;

endmodule
`default_nettype wire

// ===== core/ivr_pkg.sv
// Constants, register map and field layout of the interrupt vector resolver.
// Assumes a 20-bit CPU address space and a 32-bit AHB-Lite register bus.
package ivr_pkg;

  localparam int NSRC = 14;
  localparam int NSPC = 8;
  localparam int NPERIPH = 11;

  localparam logic [7:0] OFF_ACK = 8'h00;
  localparam logic [7:0] OFF_CTRL = 8'h04;
  localparam logic [7:0] OFF_BASE = 8'h08;
  localparam logic [7:0] OFF_MATCH = 8'h0c;
  localparam logic [7:0] OFF_VECTOR = 8'h10;
  localparam logic [7:0] OFF_LVL = 8'h40;

  localparam int CTRL_IFLAG = 0;
  localparam int CTRL_IPL_LSB = 1;
  localparam int CTRL_STEP = 4;
  localparam int CTRL_AMEN = 5;
  localparam int LVL_REQ = 3;
  localparam int ACK_NUM_LSB = 0;
  localparam int ACK_LVL_LSB = 8;
  localparam int ACK_SPC = 16;
  localparam int ACK_VALID = 31;

  localparam logic [2:0] IPL_RST = 3'h0;
  localparam logic [19:0] BASE_RST = 20'h00000;
  localparam logic [19:0] MATCH_RST = 20'h00000;
  localparam logic [2:0] LVL_RST = 3'h0;

  localparam logic [19:0] FIX_TABLE_BASE = 20'hfffdc;
  localparam logic [19:0] FIX_TABLE_LAST = 20'hfffff;
  localparam logic [5:0] SLOT_UND = 6'h00;
  localparam logic [5:0] SLOT_OVF = 6'h01;
  localparam logic [5:0] SLOT_BRK = 6'h02;
  localparam logic [5:0] SLOT_AMATCH = 6'h03;
  localparam logic [5:0] SLOT_STEP = 6'h04;
  localparam logic [5:0] SLOT_WDT = 6'h05;
  localparam logic [5:0] SLOT_DBC = 6'h06;
  localparam logic [5:0] SLOT_RST = 6'h08;
  localparam logic [31:0] BRK_ERASED = 32'hffffffff;
  localparam logic [5:0] TRAP_BRK = 6'h00;

  // Special sources, lowest index is served first.
  localparam int SP_DBC = 0;
  localparam int SP_WDT = 1;
  localparam int SP_STEP = 2;
  localparam int SP_AMATCH = 3;
  localparam int SP_BRK = 4;
  localparam int SP_UND = 5;
  localparam int SP_OVF = 6;
  localparam int SP_SWI = 7;

  // Trap number shared by each maskable source and the software trap.
  function automatic logic [5:0] src_trap(input int idx);
    case (idx)
      0: src_trap = 6'h0d;
      1: src_trap = 6'h0e;
      2: src_trap = 6'h11;
      3: src_trap = 6'h12;
      4: src_trap = 6'h13;
      5: src_trap = 6'h14;
      6: src_trap = 6'h15;
      7: src_trap = 6'h16;
      8: src_trap = 6'h17;
      9: src_trap = 6'h18;
      10: src_trap = 6'h1a;
      11: src_trap = 6'h1b;
      12: src_trap = 6'h1d;
      13: src_trap = 6'h1e;
      default: src_trap = 6'h00;
    endcase
  endfunction

  // Entry address of a four-byte vector slot above a table base.
  function automatic logic [19:0] entry_addr(input logic [19:0] base, input logic [5:0] num);
    entry_addr = base + {12'h000, num, 2'b00};
  endfunction

  // Source index of a level register, with a hit flag.
  function automatic logic [4:0] lvl_index(input logic [7:0] addr);
    logic [7:0] off;
    off = addr - OFF_LVL;
    lvl_index = 5'h00;
    if (addr >= OFF_LVL && off[1:0] == 2'b00 && off[7:2] < 6'(NSRC)) begin
      lvl_index = {1'b1, off[5:2]};
    end
  endfunction

endpackage

// ===== core/pin_evt_if.sv
// Carries the conditioned pin events from the pin stage to the resolver.
// Assumes both ends run on hclk.
`timescale 1ns/1ns
`default_nettype none
interface pin_evt_if;
  logic key_low;
  logic edge_a;
  logic edge_b;
  modport src (output key_low, output edge_a, output edge_b);
  modport dst (input key_low, input edge_a, input edge_b);
endinterface
`default_nettype wire

// ===== core/pin_event_stage.sv
// Synchronises the key and external request pins and finds their events.
// Assumes asynchronous pins and one clock, hclk.
`timescale 1ns/1ns
`default_nettype none
module pin_event_stage (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic key_input_pin,
  input wire logic external_request_pin_a,
  input wire logic external_request_pin_b,
  pin_evt_if.src evt
);

  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
    logic [2:0] stable;
    logic key_low;
    logic edge_a;
    logic edge_b;
  } pin_state_t;

  pin_state_t p_q;
  pin_state_t p_d;

  always_comb begin
    p_d = p_q;
    p_d.s1 = {external_request_pin_b, external_request_pin_a, key_input_pin};
    p_d.s2 = p_q.s1;
    p_d.s3 = p_q.s2;
    // A level counts only once two stages agree, which also rejects one-cycle glitches.
    for (int i = 0; i < 3; i++) begin
      if (p_q.s2[i] == p_q.s3[i]) begin
        p_d.stable[i] = p_q.s3[i];
      end
    end
    p_d.key_low = ~p_d.stable[0];
    p_d.edge_a = p_d.stable[1] ^ p_q.stable[1];
    p_d.edge_b = p_d.stable[2] ^ p_q.stable[2];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      p_q <= '{s1: 3'h7, s2: 3'h7, s3: 3'h7, stable: 3'h7, default: 1'b0};
    end else begin
      p_q <= p_d;
    end
  end

  assign evt.key_low = p_q.key_low;
  assign evt.edge_a = p_q.edge_a;
  assign evt.edge_b = p_q.edge_b;

endmodule
`default_nettype wire

// ===== tb/ivr_assertions.sv
// Checker of the presented interrupt and of the acknowledge word.
// Bound into the resolver; it sees the resolver's ports only.
`timescale 1ns/1ns
`default_nettype none
module ivr_assertions (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic watchdog_event,
  input wire logic debugger_break,
  input wire logic int_pending,
  input wire logic int_special,
  input wire logic [5:0] int_number,
  input wire logic [2:0] int_level,
  input wire logic [19:0] int_vector
);
  logic ack_rd;
  assign ack_rd = hsel && htrans[1] && hready && !hwrite && haddr[7:0] == 8'h00;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // The reset is asynchronous, so the outputs are judged one edge after it is seen low.
  chk_reset_quiet: assert property (disable iff (1'b0) !hresetn |=>
    hreadyout && !int_pending) else $error("output active in reset");
  chk_special_lvl: assert property (int_pending && int_special |-> int_level == 3'h0)
    else $error("special with a level");
  chk_fixed_slot: assert property (int_special && int_vector >= 20'hfffdc |->
    int_vector == 20'hfffdc + {12'h000, int_number, 2'b00}) else $error("fixed slot");
  chk_mask_number: assert property (int_pending && !int_special |-> int_number inside
    {6'h0d, 6'h0e, [6'h11:6'h18], 6'h1a, 6'h1b, 6'h1d, 6'h1e}) else $error("bad number");
  chk_mask_level: assert property (int_pending && !int_special |-> int_level != 3'h0)
    else $error("level zero presented");
  chk_ack_word: assert property (ack_rd && int_pending |=> hrdata[31] &&
    hrdata[5:0] == $past(int_number) && hrdata[10:8] == $past(int_level))
    else $error("bad acknowledge word");
  chk_brk_first: assert property (debugger_break |=> int_special &&
    int_vector == 20'hffff4) else $error("debug break not presented");
  chk_wdt_slot: assert property (watchdog_event && !debugger_break &&
    !(int_special && int_number == 6'h06) |=> int_special && int_vector == 20'hffff0)
    else $error("watchdog not presented");
endmodule
bind interrupt_vector_resolver ivr_assertions chk_u (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .watchdog_event(watchdog_event),
  .debugger_break(debugger_break), .int_pending(int_pending), .int_special(int_special),
  .int_number(int_number), .int_level(int_level), .int_vector(int_vector));
`default_nettype wire

// ===== tb/cpu_model.sv
// Model of the CPU core: instruction flow and the word at the fixed break slot.
// Runs on hclk; the bench starts one three-byte instruction per go pulse.
`timescale 1ns/1ns
`default_nettype none
module cpu_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic go,
  input wire logic [19:0] pc,
  input wire logic erased,
  output logic instr_start,
  output logic [19:0] instr_addr,
  output logic instr_done,
  output logic [31:0] break_fixed_word
);
  logic [1:0] stage_q;
  // Starts come only at first bytes; the address is scrambled between starts.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stage_q <= 2'h0;
      instr_start <= 1'h0;
      instr_done <= 1'h0;
      instr_addr <= 20'h00000;
    end else begin
      stage_q <= go ? 2'h3 : stage_q - {1'b0, stage_q != 2'h0};
      instr_start <= go;
      instr_done <= stage_q == 2'h1;
      instr_addr <= go ? pc : ~instr_addr;
    end
  end
  // An erased slot reads all ones.
  assign break_fixed_word = erased ? 32'hffffffff : 32'h000a5000;
endmodule
`default_nettype wire

// ===== tb/interrupt_vector_resolver_test.sv
// Self-checking bench: AHB-Lite tasks, pin and event pulses, vector checks.
// Assumes the CPU model supplies instruction flow and the break word.
`timescale 1ns/1ns
`default_nettype none
module interrupt_vector_resolver_test;
  logic hclk = 1'h0;
  logic hresetn = 1'h0;
  logic hsel = 1'h0, hwrite = 1'h0, go = 1'h0, erased = 1'h0;
  logic key_input_pin = 1'h1, external_request_pin_a = 1'h1, external_request_pin_b = 1'h1;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [16:0] stim = 17'h0;
  logic [19:0] pc = 20'h0, iaddr, ivec;
  logic [31:0] bfw;
  logic [5:0] inum;
  logic [2:0] ilvl;
  logic hready, hreadyout, hresp, ist, idn, ip, isp;
  logic [5:0] tn [15] = '{6'h0d, 6'h0e, 6'h11, 6'h12, 6'h13, 6'h14, 6'h15, 6'h16,
    6'h17, 6'h18, 6'h1a, 6'h1b, 6'h1d, 6'h1e, 6'h1d};
  logic [19:0] sv [6] = '{20'hffff4, 20'hffff0, 20'hfffe4, 20'hfffdc, 20'hfffe0, 20'h123a0};
  int err_total = 0;
  int n_compared = 0;
  assign hready = hreadyout;
  always #10 hclk = ~hclk;
  interrupt_vector_resolver dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .key_input_pin(key_input_pin), .external_request_pin_a(external_request_pin_a),
    .external_request_pin_b(external_request_pin_b), .periph_req(stim[10:0]),
    .instr_start(ist), .instr_addr(iaddr), .instr_done(idn),
    .undefined_opcode_instruction(stim[13]), .overflow_trap(stim[14]),
    .break_instruction(stim[15]), .break_fixed_word(bfw), .sw_trap_valid(stim[16]),
    .sw_trap_num(6'h28), .watchdog_event(stim[12]), .debugger_break(stim[11]),
    .int_pending(ip), .int_special(isp), .int_number(inum), .int_level(ilvl),
    .int_vector(ivec));
  cpu_model cpu_u (.hclk(hclk), .hresetn(hresetn), .go(go), .pc(pc), .erased(erased),
    .instr_start(ist), .instr_addr(iaddr), .instr_done(idn), .break_fixed_word(bfw));
  task automatic conclude();
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // The master never assumes a latency; every wait is bounded.
  task automatic edge_rdy(inout int n);
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'h1 && n < 50);
  endtask
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge hclk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    edge_rdy(n);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    edge_rdy(n);
    rd = hrdata;
    check({31'h0, hresp}, 32'h0);
    if (n >= 50) begin
      err_total++;
      conclude();
    end
  endtask
  task automatic pulse(input logic [16:0] m);
    @(posedge hclk);
    stim <= m;
    @(posedge hclk);
    stim <= 17'h0;
  endtask
  task automatic cpu_go(input logic [19:0] a);
    @(posedge hclk);
    go <= 1'h1;
    pc <= a;
    @(posedge hclk);
    go <= 1'h0;
  endtask
  // Waits for a presented interrupt, compares it, then acknowledges it.
  task automatic take(input logic sp, input logic [19:0] v);
    int n;
    n = 0;
    do begin
      @(negedge hclk);
      n++;
    end while (ip !== 1'h1 && n < 40);
    if (n >= 40) begin
      err_total++;
      conclude();
    end
    check({11'h0, isp, ivec}, {11'h0, sp, v});
    xfer(1'h0, 8'h00, 32'h0);
  endtask
  task automatic quiet();
    repeat (6) @(negedge hclk);
    check({31'h0, ip}, 32'h0);
  endtask
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'h1;
    xfer(1'h0, 8'h04, 32'h0);
    check(rd, 32'h0);
    xfer(1'h1, 8'h08, 32'h12300);
    xfer(1'h1, 8'h04, 32'h5);
    for (int i = 0; i < 14; i++) xfer(1'h1, 8'h40 + 8'(4 * i), 32'h3);
    for (int i = 0; i < 15; i++) begin
      @(posedge hclk);
      if (i == 0) key_input_pin <= 1'h0;
      if (i == 12 || i == 14) external_request_pin_a <= (i == 14);
      if (i == 13) external_request_pin_b <= 1'h0;
      if (i > 0 && i < 12) stim <= 17'(1 << (i - 1));
      @(posedge hclk);
      stim <= 17'h0;
      repeat (3) @(posedge hclk);
      key_input_pin <= 1'h1;
      repeat (8) @(posedge hclk);
      take(1'h0, 20'h12300 + {12'h0, tn[i], 2'h0});
      check(rd, {1'h1, 14'h0, 1'h0, 5'h0, 3'h3, 2'h0, tn[i]});
      quiet();
    end
    $display("Test peripheral sources done");
    xfer(1'h1, 8'h04, 32'h4);
    pulse(17'h1);
    quiet();
    xfer(1'h1, 8'h04, 32'h7);
    quiet();
    xfer(1'h1, 8'h44, 32'hc);
    take(1'h0, 20'h12338);
    xfer(1'h1, 8'h04, 32'h5);
    pulse(17'h6);
    take(1'h0, 20'h12344);
    take(1'h0, 20'h12348);
    xfer(1'h1, 8'h4c, 32'h5);
    pulse(17'h6);
    take(1'h0, 20'h12348);
    take(1'h0, 20'h12344);
    $display("Test masking and priority done");
    xfer(1'h1, 8'h04, 32'h0);
    pulse(17'h1f800);
    for (int k = 0; k < 6; k++) take(1'h1, sv[k]);
    erased <= 1'h1;
    pulse(17'h08000);
    take(1'h1, 20'h12300);
    xfer(1'h1, 8'h04, 32'h10);
    cpu_go(20'h04567);
    take(1'h1, 20'hfffec);
    xfer(1'h1, 8'h0c, 32'h04567);
    xfer(1'h1, 8'h04, 32'h20);
    cpu_go(20'h04567);
    take(1'h1, 20'hfffe8);
    cpu_go(20'h04566);
    quiet();
    xfer(1'h1, 8'h04, 32'h0);
    cpu_go(20'h04567);
    quiet();
    $display("Test special sources done");
    pulse(17'h00800);
    @(posedge hclk);
    hresetn <= 1'h0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'h1;
    xfer(1'h0, 8'h04, 32'h0);
    check(rd, 32'h0);
    check({31'h0, ip}, 32'h0);
    $display("Test mid-run reset done");
    conclude();
  end
endmodule
`default_nettype wire
